/* src/cca_consts.vh */
`ifndef CCA_CONSTS_VH
`define CCA_CONSTS_VH

// special-function register addresses
`define CCA_ADDR_CTRL 8'hd8
`define CCA_ADDR_CYCLE 8'hdf
`define CCA_ADDR_MODE0 8'hda
`define CCA_ADDR_LOW0 8'he0
`define CCA_ADDR_HIGH0 8'he1
`define CCA_ADDR_CNT_LOW 8'hf9
`define CCA_ADDR_CNT_HIGH 8'hfa

// counter_control_register fields
`define CCA_CTRL_RUN 6
`define CCA_CTRL_RESET 8'h00

// counter_cycle_config fields
`define CCA_CYC_RELOAD_ACCESS_SELECT 7
`define CCA_CYC_CYCLE_OVERFLOW_IRQ_ENABLE 6
`define CCA_CYC_CYCLE_OVERFLOW_FLAG 5
`define CCA_CYC_CYCLE_LENGTH_SELECT_HI 1
`define CCA_CYC_CYCLE_LENGTH_SELECT_LO 0
`define CCA_CYCLE_RESET 8'h00

// module_mode_register fields
`define CCA_MODE_PWM16 7
`define CCA_MODE_ECOM 6
`define CCA_MODE_MAT 3
`define CCA_MODE_PWM 1
`define CCA_MODE_ECCF 0
`define CCA_MODE_RESET 8'h00
`define CCA_CMP_RESET 16'h0000

`endif

/* src/cca_cycle_overflow_flag.v */
`include "cca_consts.vh"
`default_nettype none

// flags the step on which the selected low bits of the counter wrap
module cca_cycle_overflow_flag (
    input wire clock, // system clock
    input wire rst, // synchronous reset
    input wire run, // counter advances this cycle
    input wire [15:0] count, // main_array_counter value
    input wire [1:0] cycle_length_select, // cycle_length_select
    output reg ovf_q // one-cycle wrap pulse
);

reg [10:0] mask;

always @* begin
    case (cycle_length_select)
        2'h0: mask = 11'h0ff;
        2'h1: mask = 11'h1ff;
        2'h2: mask = 11'h3ff;
        default: mask = 11'h7ff;
    endcase
end

always @(posedge clock) begin
    if (rst) begin
        ovf_q <= 1'b0;
    end else begin
        ovf_q <= run & ((count[10:0] & mask) == mask);
    end
end

endmodule
`default_nettype wire

/* src/cca_chan.v */
`include "cca_consts.vh"
`default_nettype none

// one compare module: mode, compare pair, reload pair, match and pwm
module cca_chan (
    input wire clock, // system clock
    input wire rst, // synchronous reset
    input wire [15:0] count, // main_array_counter value
    input wire [1:0] cycle_length_select, // cycle_length_select
    input wire reload_access_select, // reload_access_select
    input wire cyc_end, // cycle wrap pulse
    input wire wr_mode, // write module_mode_register
    input wire wr_low, // write compare_low_byte address
    input wire wr_high, // write compare_high_byte address
    input wire [7:0] wdata, // write data
    output reg [7:0] mode_q, // module_mode_register
    output reg [15:0] cmp_q, // compare_register_pair
    output reg [15:0] reload_q, // auto-reload pair
    output wire match_set, // first cycle of equality in timer mode
    output reg pwm_q // pwm output
);

reg eq_q;
reg [15:0] cmp_d;
wire eq;
wire sw_timer;
wire narrow;

function [15:0] len_mask;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: len_mask = 16'h00ff;
            2'h1: len_mask = 16'h01ff;
            2'h2: len_mask = 16'h03ff;
            default: len_mask = 16'h07ff;
        endcase
    end
endfunction

assign eq = count == cmp_q;
assign sw_timer = mode_q[`CCA_MODE_ECOM] & mode_q[`CCA_MODE_MAT];
// only the first cycle of equality counts, a stopped counter stays equal
assign match_set = sw_timer & eq & ~eq_q;
assign narrow = mode_q[`CCA_MODE_PWM] & ~mode_q[`CCA_MODE_PWM16];

always @* begin
    cmp_d = cmp_q;
    if (wr_low & ~reload_access_select) begin
        cmp_d[7:0] = wdata;
    end
    if (wr_high & ~reload_access_select) begin
        cmp_d[15:8] = wdata;
    end
    if (cyc_end & narrow & (cycle_length_select != 2'h0)) begin
        cmp_d = (cmp_d & ~len_mask(cycle_length_select)) | (reload_q & len_mask(cycle_length_select));
    end
end

always @(posedge clock) begin
    if (rst) begin
        mode_q <= `CCA_MODE_RESET;
        cmp_q <= `CCA_CMP_RESET;
        reload_q <= `CCA_CMP_RESET;
        eq_q <= 1'b0;
        pwm_q <= 1'b0;
    end else begin
        eq_q <= eq;
        cmp_q <= cmp_d;
        if (wr_mode) begin
            mode_q <= wdata;
        end
        if (wr_low) begin
            mode_q[`CCA_MODE_ECOM] <= 1'b0;
        end
        if (wr_high) begin
            mode_q[`CCA_MODE_ECOM] <= 1'b1;
        end
        if (wr_low & reload_access_select) begin
            reload_q[7:0] <= wdata;
        end
        if (wr_high & reload_access_select) begin
            reload_q[15:8] <= wdata;
        end
        if (~mode_q[`CCA_MODE_PWM] | ~mode_q[`CCA_MODE_ECOM]) begin
            pwm_q <= 1'b0;
        end else if (mode_q[`CCA_MODE_PWM16]) begin
            pwm_q <= count < cmp_q;
        end else begin
            pwm_q <= (count & len_mask(cycle_length_select)) <
                (cmp_q & len_mask(cycle_length_select));
        end
    end
end

endmodule
`default_nettype wire

/* src/cca_top.v */
// How it works
// - counter compared against each 16-bit compare pair
// - equality sets that module's match flag
// - match flag interrupts only when enabled
// - flag never auto-cleared; software clears it
// - timer mode needs comparator and match enables
// - low compare write clears comparator enable
// - high compare write sets comparator enable
// - bit 7 steers compare addresses to reload
// - reload only used in 9-11 bit pwm
// - bit 6 masks cycle overflow interrupt
// - overflow flag from bit chosen by length
// - overflow flag set by hardware/software, sticky
// - bits 4:2 read zero, writes ignored
// - length field selects 8,9,10,11 bits
// - 16-bit pwm channels ignore length field
`include "cca_consts.vh"
`default_nettype none

module cca_top (
    input wire clock, // system clock, 50 MHz
    input wire rst, // synchronous reset, active high
    input wire [7:0] sfr_addr, // register address
    input wire [7:0] sfr_wdata, // write data
    input wire sfr_wr, // write strobe
    input wire sfr_rd, // read strobe
    output reg [7:0] sfr_rdata_q, // read data, one cycle after strobe
    output reg irq_q, // array interrupt request
    output reg [2:0] pwm_out_q // per-module pwm outputs
);

localparam NCH = 3;

////////////////////////////////////////////////////////////////////////

reg [15:0] cnt_q;
reg run_q;
reg [NCH-1:0] flag_q;
reg [NCH-1:0] flag_d;
reg reload_access_select_q;
reg cycle_overflow_irq_enable_q;
reg cycle_overflow_flag_q;
reg cycle_overflow_flag_d;
reg [1:0] cycle_length_select_q;
reg [7:0] rd_d;
reg irq_d;
// separate loop indices so each combinational process owns its own
integer i;
integer j;

wire ovf;
wire wr_ctrl;
wire wr_cycle;
wire [NCH*8-1:0] mode_all;
wire [NCH*16-1:0] cmp_all;
wire [NCH*16-1:0] reload_all;
wire [NCH-1:0] set_all;
wire [NCH-1:0] pwm_all;

assign wr_ctrl = sfr_wr & (sfr_addr == `CCA_ADDR_CTRL);
assign wr_cycle = sfr_wr & (sfr_addr == `CCA_ADDR_CYCLE);

////////////////////////////////////////////////////////////////////////
// main counter and cycle wrap

always @(posedge clock) begin
    if (rst) begin
        cnt_q <= 16'h0000;
    end else if (run_q) begin
        cnt_q <= cnt_q + 16'h0001;
    end
end

cca_cycle_overflow_flag u_cycle_overflow_flag (
    .clock(clock),
    .rst(rst),
    .run(run_q),
    .count(cnt_q),
    .cycle_length_select(cycle_length_select_q),
    .ovf_q(ovf)
);

////////////////////////////////////////////////////////////////////////
// compare modules

genvar gi;
generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
        cca_chan u_chan (
            .clock(clock),
            .rst(rst),
            .count(cnt_q),
            .cycle_length_select(cycle_length_select_q),
            .reload_access_select(reload_access_select_q),
            .cyc_end(ovf),
            .wr_mode(sfr_wr &
                (sfr_addr == `CCA_ADDR_MODE0 + gi[7:0])),
            .wr_low(sfr_wr &
                (sfr_addr == `CCA_ADDR_LOW0 + {gi[6:0], 1'b0})),
            .wr_high(sfr_wr &
                (sfr_addr == `CCA_ADDR_HIGH0 + {gi[6:0], 1'b0})),
            .wdata(sfr_wdata),
            .mode_q(mode_all[gi*8 +: 8]),
            .cmp_q(cmp_all[gi*16 +: 16]),
            .reload_q(reload_all[gi*16 +: 16]),
            .match_set(set_all[gi]),
            .pwm_q(pwm_all[gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// flags: a hardware set in the clearing cycle still wins

always @* begin
    flag_d = flag_q;
    if (wr_ctrl) begin
        flag_d = sfr_wdata[NCH-1:0];
    end
    flag_d = flag_d | set_all;
    cycle_overflow_flag_d = cycle_overflow_flag_q;
    if (wr_cycle) begin
        cycle_overflow_flag_d = sfr_wdata[`CCA_CYC_CYCLE_OVERFLOW_FLAG];
    end
    cycle_overflow_flag_d = cycle_overflow_flag_d | ovf;
end

// level request from flags held in registers, cleared only by software
always @* begin
    irq_d = 1'b0;
    for (i = 0; i < NCH; i = i + 1) begin
        if (flag_q[i] & mode_all[i*8 + `CCA_MODE_ECCF]) begin
            irq_d = 1'b1;
        end
    end
    if (cycle_overflow_flag_q & cycle_overflow_irq_enable_q) begin
        irq_d = 1'b1;
    end
end

always @(posedge clock) begin
    if (rst) begin
        run_q <= 1'b0;
        flag_q <= {NCH{1'b0}};
        reload_access_select_q <= 1'b0;
        cycle_overflow_irq_enable_q <= 1'b0;
        cycle_overflow_flag_q <= 1'b0;
        cycle_length_select_q <= 2'h0;
        irq_q <= 1'b0;
        pwm_out_q <= 3'h0;
    end else begin
        flag_q <= flag_d;
        cycle_overflow_flag_q <= cycle_overflow_flag_d;
        irq_q <= irq_d;
        pwm_out_q <= pwm_all;
        if (wr_ctrl) begin
            run_q <= sfr_wdata[`CCA_CTRL_RUN];
        end
        if (wr_cycle) begin
            reload_access_select_q <= sfr_wdata[`CCA_CYC_RELOAD_ACCESS_SELECT];
            cycle_overflow_irq_enable_q <= sfr_wdata[`CCA_CYC_CYCLE_OVERFLOW_IRQ_ENABLE];
            cycle_length_select_q <= sfr_wdata[`CCA_CYC_CYCLE_LENGTH_SELECT_HI:`CCA_CYC_CYCLE_LENGTH_SELECT_LO];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// read port; unmapped addresses read zero

always @* begin
    rd_d = 8'h00;
    case (sfr_addr)
        `CCA_ADDR_CTRL: rd_d = {1'b0, run_q, 3'h0, flag_q};
        `CCA_ADDR_CYCLE: rd_d = {reload_access_select_q, cycle_overflow_irq_enable_q, cycle_overflow_flag_q, 3'h0,
            cycle_length_select_q};
        `CCA_ADDR_CNT_LOW: rd_d = cnt_q[7:0];
        `CCA_ADDR_CNT_HIGH: rd_d = cnt_q[15:8];
        default: rd_d = 8'h00;
    endcase
    for (j = 0; j < NCH; j = j + 1) begin
        if (sfr_addr == `CCA_ADDR_MODE0 + j[7:0]) begin
            rd_d = mode_all[j*8 +: 8];
        end
        if (sfr_addr == `CCA_ADDR_LOW0 + {j[6:0], 1'b0}) begin
            rd_d = reload_access_select_q ? reload_all[j*16 +: 8] :
                cmp_all[j*16 +: 8];
        end
        if (sfr_addr == `CCA_ADDR_HIGH0 + {j[6:0], 1'b0}) begin
            rd_d = reload_access_select_q ? reload_all[j*16+8 +: 8] :
                cmp_all[j*16+8 +: 8];
        end
    end
end

always @(posedge clock) begin
    if (rst) begin
        sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
        sfr_rdata_q <= rd_d;
    end
end

endmodule
`default_nettype wire

/* tb/cca_chk_sva.sv */
`include "cca_consts.vh"
`default_nettype none
module cca_chk (
    input wire logic clock, // system clock
    input wire logic rst, // sync reset
    input wire logic [7:0] sfr_addr, // address
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_wr, // write strobe
    input wire logic sfr_rd, // read strobe
    input wire logic [7:0] sfr_rdata_q, // read data
    input wire logic irq_q, // interrupt
    input wire logic [2:0] pwm_out_q // pwm
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cycle_overflow_irq_enable_q;
    logic [2:0] eccf_q;
    logic [1:0] qcnt_q;
    wire cfg_w = sfr_wr && sfr_addr == `CCA_ADDR_CYCLE;
    wire cfg_r = sfr_rd && sfr_addr == `CCA_ADDR_CYCLE;
    wire mode_r = sfr_rd && sfr_addr == `CCA_ADDR_MODE0;
    //////////////////////////////////////////////////
    // shadow of every interrupt enable; two quiet cycles cover irq latency
    always_ff @(posedge clock) begin
        if (rst) begin
            cycle_overflow_irq_enable_q <= 1'b0;
            eccf_q <= 3'h0;
            qcnt_q <= 2'h0;
        end else begin
            if (cfg_w)
                cycle_overflow_irq_enable_q <= sfr_wdata[6];
            for (int i = 0; i < 3; i++)
                if (sfr_wr && sfr_addr == `CCA_ADDR_MODE0 + 8'(i))
                    eccf_q[i] <= sfr_wdata[0];
            if (cycle_overflow_irq_enable_q || eccf_q != 3'h0)
                qcnt_q <= 2'h0;
            else if (qcnt_q != 2'h3)
                qcnt_q <= qcnt_q + 2'h1;
        end
    end
    //////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    reset_clear_a: assert property ($fell(rst) |->
        sfr_rdata_q == 8'h00 && !irq_q && pwm_out_q == 3'h0)
        else $error("outputs not clear after reset");
    rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
        else $error("read data moved without a read");
    unused_bits_a: assert property (
        cfg_r |=> sfr_rdata_q[4:2] == 3'b000)
        else $error("cycle config bits 4:2 not zero");
    cfg_back_a: assert property (
        cfg_w ##1 cfg_r |=>
        (sfr_rdata_q & 8'hc3) == ($past(sfr_wdata, 2) & 8'hc3))
        else $error("cycle config readback wrong");
    cycle_overflow_flag_irq_a: assert property (
        cfg_r ##1 sfr_rdata_q[6:5] == 2'b11 |-> ##[0:1] irq_q)
        else $error("enabled cycle overflow gave no irq");
    quiet_irq_a: assert property (qcnt_q[1] |-> !irq_q)
        else $error("irq with all enables off");
    mode_back_a: assert property (
        sfr_wr && sfr_addr == `CCA_ADDR_MODE0 ##1 mode_r |=>
        sfr_rdata_q == $past(sfr_wdata, 2))
        else $error("mode register readback wrong");
    low_clears_a: assert property (
        sfr_wr && sfr_addr == `CCA_ADDR_LOW0 ##1 mode_r |=>
        !sfr_rdata_q[6])
        else $error("low byte write left comparator on");
    high_sets_a: assert property (
        sfr_wr && sfr_addr == `CCA_ADDR_HIGH0 ##1 mode_r |=>
        sfr_rdata_q[6])
        else $error("high byte write left comparator off");
    cover property (cfg_r ##1 sfr_rdata_q[5]);
    cover property ($rose(irq_q));
    cover property ($fell(irq_q));
endmodule
`default_nettype wire

/* tb/cca_top_tb_top.sv */
`include "cca_consts.vh"
`default_nettype none
module cca_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CY = `CCA_ADDR_CYCLE;
    localparam logic [7:0] CT = `CCA_ADDR_CTRL;
    localparam logic [7:0] M0 = `CCA_ADDR_MODE0;
    localparam logic [7:0] L0 = `CCA_ADDR_LOW0;
    localparam logic [7:0] H0 = `CCA_ADDR_HIGH0;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata_q, v, lo;
    logic irq_q;
    logic [2:0] pwm_out_q;
    int n_mismatch = 0;
    int comparisons = 0;
    cca_top i_cca_top (.clock, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
        .sfr_rd, .sfr_rdata_q, .irq_q, .pwm_out_q);
    initial begin
        forever #10 clock = ~clock;
    end
    //////////////////////////////////////////////////
    // strobes stay up until the next put, so every write is followed by one
    task automatic put(input logic [7:0] a, d, input logic w, r);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = r;
    endtask
    task automatic wr(input logic [7:0] a, d);
        put(a, d, 1'b1, 1'b0);
    endtask
    task automatic idle(input int n);
        put(8'h00, 8'h00, 1'b0, 1'b0);
        repeat (n) @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        put(a, 8'h00, 1'b0, 1'b1);
        put(a, 8'h00, 1'b0, 1'b0);
        q = sfr_rdata_q;
    endtask
    task automatic chk(input string s, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rchk(input string s, input logic [7:0] a, e);
        rd(a, v);
        chk(s, e, v);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    //////////////////////////////////////////////////
    initial begin
        repeat (4000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        rchk("cfg", CY, 8'h00);
        rchk("ctrl", CT, 8'h00);
        wr(CY, 8'hff);
        rchk("cfg", CY, 8'he3);
        chk("irq", 8'h01, {7'h0, irq_q});
        rchk("cfg", CY, 8'he3);
        wr(CY, 8'h20);
        idle(3);
        chk("irq", 8'h00, {7'h0, irq_q});
        wr(CY, 8'h00);
        rchk("cfg", CY, 8'h00);
        $display("test config done");
        wr(L0, 8'h34);
        wr(H0, 8'h12);
        wr(CY, 8'h80);
        wr(L0, 8'h78);
        wr(H0, 8'h56);
        rchk("reload low", L0, 8'h78);
        rchk("reload high", H0, 8'h56);
        wr(CY, 8'h00);
        rchk("cmp low", L0, 8'h34);
        rchk("cmp high", H0, 8'h12);
        $display("test reload select done");
        wr(M0, 8'h49);
        rchk("mode", M0, 8'h49);
        wr(L0, 8'h00);
        rchk("mode", M0, 8'h09);
        wr(H0, 8'h01);
        rchk("mode", M0, 8'h49);
        wr(8'he2, 8'h10);
        wr(8'he3, 8'h00);
        wr(8'hdb, 8'h48);
        $display("test comparator enable done");
        // channel 1 matches at 0x10 without irq, channel 0 at 0x100 with
        wr(CT, 8'h40);
        idle(30);
        rchk("ctrl", CT, 8'h42);
        chk("irq", 8'h00, {7'h0, irq_q});
        idle(260);
        rchk("ctrl", CT, 8'h43);
        chk("irq", 8'h01, {7'h0, irq_q});
        idle(20);
        rchk("ctrl", CT, 8'h43);
        wr(CT, 8'h00);
        idle(2);
        rchk("ctrl", CT, 8'h00);
        chk("irq", 8'h00, {7'h0, irq_q});
        $display("test match done");
        rchk("cfg", CY, 8'h20);
        wr(CY, 8'h41);
        wr(CT, 8'h40);
        idle(250);
        wr(CT, 8'h00);
        rchk("cfg", CY, 8'h61);
        chk("irq", 8'h01, {7'h0, irq_q});
        // 10-bit length must skip the 0x2ff wrap that 8 bits would flag
        rd(`CCA_ADDR_CNT_LOW, lo);
        rd(`CCA_ADDR_CNT_HIGH, v);
        wr(CY, 8'h02);
        wr(CT, 8'h40);
        idle(int'(16'h03f0 - {v, lo}) - 2);
        wr(CT, 8'h00);
        rchk("cfg", CY, 8'h02);
        wr(CT, 8'h40);
        idle(30);
        wr(CT, 8'h00);
        rchk("cfg", CY, 8'h22);
        $display("test cycle length done");
        // channel 2 compare 0x0100, counter parked just past 0x400
        wr(8'he4, 8'h00);
        wr(8'he5, 8'h01);
        wr(8'hdc, 8'hc2);
        idle(3);
        chk("pwm16", 8'h00, {5'h0, pwm_out_q});
        wr(8'hdc, 8'h42);
        idle(3);
        chk("pwm narrow", 8'h04, {5'h0, pwm_out_q});
        $display("test pwm done");
        wrap_up();
    end
endmodule
bind cca_top cca_chk i_cca_chk (.clock, .rst, .sfr_addr, .sfr_wdata,
    .sfr_wr, .sfr_rd, .sfr_rdata_q, .irq_q, .pwm_out_q);
`default_nettype wire
